/* hdl/prhi_core.sv */
// run/halt sequencing, interrupt taking and state save for one processor
`timescale 1ns/1ps
`include "prhi_map.svh"
// Function
// - status bit 11 picks idle or active
// - idle loops polling halt, cpu checks interrupts
// - active executes next instruction or interrupt
// - control bit0 is halt, bit1 run
// - halt sampled at each instruction end
// - halt clear and run set means running or waiting
// - halt and run set: one step each
// - thirteen registers, all but control readable only while halted
// - take system level only enabled, uninhibited
// - status bits 15..12 mask levels 4..1
// - taking interrupt disables levels 4..1
// - save module, status, pc in slot
// - load vector into pc, interrupts off
// - return restores status and pc
// - later interrupt overwrites the same slot
// - self levels 5 unimplemented, 6 abort
// - abort releases bus and reports it
// - self slots per processor number
// - bus control unit processor is number 00
// - three status flags set by instructions
// - control register reachable while running
module prhi_core
(
	input  wire logic                   core_clk_i,     // processor clock
	input  wire logic                   rst_i,          // async reset, high
	input  wire logic                   bus_control_unit_i, // strap: cpu
	input  wire logic [1:0]             proc_num_i,     // secondary number
	input  wire prhi_pkg::prhi_panel_t  panel_i,        // panel access
	input  wire logic                   step_req_i,     // panel step pulse
	output logic [15:0]                 panel_rdata_o,  // panel read data
	output logic                        panel_ack_o,    // panel access done
	output logic                        instr_start_o,  // start one instr
	input  wire prhi_pkg::prhi_instr_t  instr_i,        // instr end report
	input  wire prhi_pkg::prhi_gp_wr_t  gp_wr_i,        // general reg write
	input  wire logic [3:0]             sys_irq_i,      // levels 4..1
	input  wire logic [15:0]            sys_mod_addr_i, // requester address
	input  wire logic                   master_interrupt_inhibit_i, // inhibit
	output logic [3:0]                  sys_irq_ack_o,  // level taken pulse
	output prhi_pkg::prhi_mem_t         mem_o,          // executive access
	input  wire logic                   mem_ack_i,      // memory done
	input  wire logic [15:0]            mem_rdata_i,    // memory read data
	output logic                        bus_release_o,  // abort pulse
	output logic                        halted_o,       // in halt state
	output logic [15:0]                 status_o,       // processor status
	output logic [15:0]                 pc_o,           // program counter
	output logic [1:0]                  proc_num_o      // own number
);
	prhi_pkg::prhi_state_t state;
	logic [15:0] processor_status;
	logic [15:0] program_counter_reg;
	logic [1:0]  halt_run_control;
	logic [15:0] gp_regs [`PRHI_NUM_GP];
	logic [1:0]  save_cnt;
	logic [2:0]  cur_level;
	logic [15:0] save_item;
	logic [15:0] save_status;
	logic [15:0] save_pc;
	logic [1:0]  proc_num;
	logic        is_cpu;
	logic        strap_done;
	logic        irq_pend;
	logic [2:0]  irq_level;
	logic [3:0]  irq_onehot;
	logic [15:0] slot_addr;
	logic        halt_ff;
	logic        run_ff;
	logic        active_bit;
	logic        take_sys;
	logic        take_self;
	logic        step_go;
	logic        instr_end;
	logic [2:0]  self_level;

	assign halt_ff    = halt_run_control[`PRHI_HALT_BIT];
	assign run_ff     = halt_run_control[`PRHI_RUN_BIT];
	assign active_bit = processor_status[`PRHI_ACTIVE_BIT];

	// where to go after an instruction or a service is complete
	function automatic prhi_pkg::prhi_state_t end_state(input logic h,
		input logic r, input logic act);
		if (h || !r)
			end_state = prhi_pkg::PRHI_ST_HALT;
		else if (act)
			end_state = prhi_pkg::PRHI_ST_ACTIVE;
		else
			end_state = prhi_pkg::PRHI_ST_IDLE;
	endfunction : end_state

	prhi_irq_sel u_irq_sel
	(
		.sys_irq_i (sys_irq_i),
		.mask_i    (processor_status[`PRHI_MASK_HI:`PRHI_MASK_LO]),
		.inhibit_i (master_interrupt_inhibit_i),
		.is_cpu_i  (is_cpu),
		.pend_o    (irq_pend),
		.level_o   (irq_level),
		.onehot_o  (irq_onehot)
	);

	prhi_slot_addr u_slot_addr
	(
		.level_i    (cur_level),
		.proc_num_i (proc_num),
		.word_i     (save_cnt),
		.addr_o     (slot_addr)
	);

	always_comb
	begin
		take_sys  = 1'b0;
		step_go   = 1'b0;
		instr_end = (state == prhi_pkg::PRHI_ST_EXEC) && instr_i.done;
		take_self = instr_end && (instr_i.unimpl || instr_i.abort);
		self_level = instr_i.abort ? `PRHI_LVL_ABORT : `PRHI_LVL_UNIMPL;
		case (state)
			prhi_pkg::PRHI_ST_IDLE, prhi_pkg::PRHI_ST_WAIT:
				take_sys = irq_pend && run_ff && !halt_ff;
			prhi_pkg::PRHI_ST_ACTIVE:
				take_sys = irq_pend;
			prhi_pkg::PRHI_ST_HALT:
				step_go = halt_ff && run_ff && step_req_i;
			default:
				take_sys = 1'b0;
		endcase
		instr_start_o = step_go ||
			(state == prhi_pkg::PRHI_ST_ACTIVE && !take_sys);
		sys_irq_ack_o = take_sys ? irq_onehot : 4'h0;
		bus_release_o = instr_end && instr_i.abort;
	end

	// straps taken once after reset release; the cpu is number 00
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			strap_done <= 1'b0;
			proc_num   <= `PRHI_CPU_NUM;
			is_cpu     <= 1'b0;
		end
		else if (!strap_done)
		begin
			strap_done <= 1'b1;
			is_cpu     <= bus_control_unit_i;
			proc_num   <= bus_control_unit_i ? `PRHI_CPU_NUM
				: proc_num_i;
		end
	end

	// sequencer
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			state <= prhi_pkg::PRHI_ST_HALT;
		else
			case (state)
				prhi_pkg::PRHI_ST_HALT:
					if (run_ff && !halt_ff)
						state <= end_state(1'b0, 1'b1, active_bit);
					else if (step_go)
						state <= prhi_pkg::PRHI_ST_EXEC;
				prhi_pkg::PRHI_ST_IDLE:
					if (halt_ff || !run_ff)
						state <= prhi_pkg::PRHI_ST_HALT;
					else if (take_sys)
						state <= prhi_pkg::PRHI_ST_SAVE;
					else if (active_bit)
						state <= prhi_pkg::PRHI_ST_ACTIVE;
				prhi_pkg::PRHI_ST_ACTIVE:
					if (take_sys)
						state <= prhi_pkg::PRHI_ST_SAVE;
					else
						state <= prhi_pkg::PRHI_ST_EXEC;
				prhi_pkg::PRHI_ST_EXEC:
					if (take_self)
						state <= prhi_pkg::PRHI_ST_SAVE;
					else if (instr_end && instr_i.return_from_interrupt)
						state <= prhi_pkg::PRHI_ST_RESTORE;
					else if (instr_end && instr_i.wait_op && !halt_ff)
						state <= prhi_pkg::PRHI_ST_WAIT;
					else if (instr_end)
						state <= end_state(halt_ff, run_ff, active_bit);
				prhi_pkg::PRHI_ST_WAIT:
					if (halt_ff || !run_ff)
						state <= prhi_pkg::PRHI_ST_HALT;
					else if (take_sys)
						state <= prhi_pkg::PRHI_ST_SAVE;
				prhi_pkg::PRHI_ST_SAVE:
					if (mem_ack_i && save_cnt == `PRHI_W_PC)
						state <= prhi_pkg::PRHI_ST_VECT;
				prhi_pkg::PRHI_ST_VECT:
					if (mem_ack_i)
						state <= end_state(halt_ff, run_ff, active_bit);
				prhi_pkg::PRHI_ST_RESTORE:
					if (mem_ack_i && save_cnt == `PRHI_W_PC)
						state <= end_state(halt_ff, run_ff,
							processor_status[`PRHI_ACTIVE_BIT]);
				default:
					state <= prhi_pkg::PRHI_ST_HALT;
			endcase
	end

	// slot word counter, level and captured state for the save
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			save_cnt    <= `PRHI_W_ITEM;
			cur_level   <= 3'h1;
			save_item   <= 16'h0000;
			save_status <= 16'h0000;
			save_pc     <= 16'h0000;
		end
		else if (take_sys || take_self)
		begin
			save_cnt    <= `PRHI_W_ITEM;
			cur_level   <= take_self ? self_level : irq_level;
			save_item   <= take_self ? instr_i.item
				: sys_mod_addr_i;
			save_status <= processor_status;
			save_pc     <= take_self ? program_counter_reg
				: program_counter_reg;
		end
		else if (instr_end && instr_i.return_from_interrupt)
			save_cnt <= `PRHI_W_STATUS;
		else if (mem_ack_i)
			save_cnt <= save_cnt + 2'h1;
	end

	// executive memory request, word order item, status, pc, vector
	always_comb
	begin
		mem_o.req   = 1'b0;
		mem_o.wr    = 1'b0;
		mem_o.addr  = slot_addr;
		mem_o.wdata = save_item;
		case (state)
			prhi_pkg::PRHI_ST_SAVE:
			begin
				mem_o.req = 1'b1;
				mem_o.wr  = 1'b1;
				if (save_cnt == `PRHI_W_STATUS)
					mem_o.wdata = save_status;
				else if (save_cnt == `PRHI_W_PC)
					mem_o.wdata = save_pc;
			end
			prhi_pkg::PRHI_ST_VECT, prhi_pkg::PRHI_ST_RESTORE:
				mem_o.req = 1'b1;
			default:
				mem_o.req = 1'b0;
		endcase
	end

	// halt/run control is reachable whatever the state
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			halt_run_control <= `PRHI_HRC_RST;
		else if (panel_i.sel && panel_i.wr && panel_i.idx == `PRHI_IDX_HRC)
			halt_run_control <= panel_i.wdata[1:0];
	end

	// status register
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			processor_status <= `PRHI_STATUS_RST;
		else if (take_sys || take_self)
			processor_status[`PRHI_MASK_HI:`PRHI_MASK_LO]
				<= `PRHI_MASK_ALL;
		else if (state == prhi_pkg::PRHI_ST_RESTORE && mem_ack_i &&
			save_cnt == `PRHI_W_STATUS)
			processor_status <= mem_rdata_i;
		else if (instr_end && instr_i.st_we)
			processor_status <= instr_i.st_val;
		else if (instr_end && instr_i.flag_we)
			processor_status[`PRHI_FLAG_HI:`PRHI_FLAG_LO]
				<= instr_i.flags;
		else if (state == prhi_pkg::PRHI_ST_HALT && panel_i.sel &&
			panel_i.wr && panel_i.idx == `PRHI_IDX_STATUS)
			processor_status <= panel_i.wdata;
	end

	// program counter
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			program_counter_reg <= `PRHI_PC_RST;
		else if (state == prhi_pkg::PRHI_ST_VECT && mem_ack_i)
			program_counter_reg <= mem_rdata_i;
		else if (state == prhi_pkg::PRHI_ST_RESTORE && mem_ack_i &&
			save_cnt == `PRHI_W_PC)
			program_counter_reg <= mem_rdata_i;
		else if (instr_end && !take_self)
			program_counter_reg <= instr_i.next_pc;
		else if (state == prhi_pkg::PRHI_ST_HALT && panel_i.sel &&
			panel_i.wr && panel_i.idx == `PRHI_IDX_PC)
			program_counter_reg <= panel_i.wdata;
	end

	// general registers, datapath first, panel only while halted
	always_ff @(posedge core_clk_i)
	begin
		if (gp_wr_i.we && gp_wr_i.idx < 4'(`PRHI_NUM_GP))
			gp_regs[gp_wr_i.idx] <= gp_wr_i.data;
		else if (state == prhi_pkg::PRHI_ST_HALT && panel_i.sel &&
			panel_i.wr && panel_i.idx >= `PRHI_IDX_GP_LO &&
			panel_i.idx < 4'(`PRHI_NUM_REGS))
			gp_regs[panel_i.idx - `PRHI_IDX_GP_LO] <= panel_i.wdata;
	end

	// panel reads: control always, the rest only while halted
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			panel_ack_o   <= 1'b0;
			panel_rdata_o <= 16'h0000;
		end
		else
		begin
			panel_ack_o   <= panel_i.sel;
			panel_rdata_o <= 16'h0000;
			if (panel_i.sel && !panel_i.wr)
			begin
				if (panel_i.idx == `PRHI_IDX_HRC)
					panel_rdata_o <= {14'h0000, halt_run_control};
				else if (state != prhi_pkg::PRHI_ST_HALT)
					panel_rdata_o <= 16'h0000;
				else if (panel_i.idx == `PRHI_IDX_PC)
					panel_rdata_o <= program_counter_reg;
				else if (panel_i.idx == `PRHI_IDX_STATUS)
					panel_rdata_o <= processor_status;
				else if (panel_i.idx < 4'(`PRHI_NUM_REGS))
					panel_rdata_o <= gp_regs[panel_i.idx -
						`PRHI_IDX_GP_LO];
			end
		end
	end

	assign halted_o   = (state == prhi_pkg::PRHI_ST_HALT);
	assign status_o   = processor_status;
	assign pc_o       = program_counter_reg;
	assign proc_num_o = proc_num;

	property p_halt_end;
		@(posedge core_clk_i) disable iff (rst_i)
		instr_end && halt_ff && !take_self &&
			!instr_i.return_from_interrupt
			|=> state == prhi_pkg::PRHI_ST_HALT;
	endproperty
	a_halt_end: assert property (p_halt_end)
		else $error("halt not honoured at instruction end");

	property p_mask_take;
		@(posedge core_clk_i) disable iff (rst_i)
		(take_sys || take_self) |=> processor_status[15:12] == 4'hf;
	endproperty
	a_mask_take: assert property (p_mask_take)
		else $error("levels not disabled on interrupt");

	property p_inhibit;
		@(posedge core_clk_i) disable iff (rst_i)
		master_interrupt_inhibit_i || !is_cpu |-> sys_irq_ack_o == 4'h0;
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("system interrupt taken while inhibited");

	property p_mask_en;
		@(posedge core_clk_i) disable iff (rst_i)
		take_sys |-> (processor_status[15:12] & sys_irq_ack_o) == 4'h0;
	endproperty
	a_mask_en: assert property (p_mask_en)
		else $error("masked level taken");

	property p_sys_slot;
		@(posedge core_clk_i) disable iff (rst_i)
		take_sys && sys_irq_ack_o == 4'h4
			|=> mem_o.req && mem_o.wr && mem_o.addr == 16'h0010;
	endproperty
	a_sys_slot: assert property (p_sys_slot)
		else $error("level 3 save not at its slot");

	property p_vec_pc;
		@(posedge core_clk_i) disable iff (rst_i)
		state == prhi_pkg::PRHI_ST_VECT && mem_ack_i
			|=> program_counter_reg == $past(mem_rdata_i);
	endproperty
	a_vec_pc: assert property (p_vec_pc)
		else $error("vector not loaded into pc");

	property p_abort;
		@(posedge core_clk_i) disable iff (rst_i)
		instr_end && instr_i.abort |-> bus_release_o ##1
			(cur_level == 3'h6 && state == prhi_pkg::PRHI_ST_SAVE);
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort not reported at level 6");

	property p_hold_00;
		@(posedge core_clk_i) disable iff (rst_i)
		state == prhi_pkg::PRHI_ST_HALT && !run_ff
			|-> !instr_start_o ##1 state == prhi_pkg::PRHI_ST_HALT;
	endproperty
	a_hold_00: assert property (p_hold_00)
		else $error("instruction started without run");

	property p_panel_gate;
		@(posedge core_clk_i) disable iff (rst_i)
		panel_i.sel && !panel_i.wr && panel_i.idx == 4'h0 &&
			state != prhi_pkg::PRHI_ST_HALT |=> panel_rdata_o == 16'h0000;
	endproperty
	a_panel_gate: assert property (p_panel_gate)
		else $error("register shown while running");
endmodule : prhi_core

/* hdl/prhi_irq_sel.sv */
// picks the highest enabled system interrupt level
`timescale 1ns/1ps
module prhi_irq_sel
(
	input  wire logic [3:0] sys_irq_i,   // request per level, bit0 = level 1
	input  wire logic [3:0] mask_i,      // status mask, 1 disables
	input  wire logic       inhibit_i,   // master interrupt inhibit
	input  wire logic       is_cpu_i,    // only the cpu takes system levels
	output logic            pend_o,      // an enabled request exists
	output logic [2:0]      level_o,     // chosen level 1..4
	output logic [3:0]      onehot_o     // chosen level one-hot
);
	logic [3:0] enabled;

	always_comb
	begin
		enabled  = sys_irq_i & ~mask_i & {4{~inhibit_i & is_cpu_i}};
		pend_o   = |enabled;
		level_o  = 3'h0;
		onehot_o = 4'h0;
		if (enabled[3])
		begin
			level_o  = 3'h4;
			onehot_o = 4'h8;
		end
		else if (enabled[2])
		begin
			level_o  = 3'h3;
			onehot_o = 4'h4;
		end
		else if (enabled[1])
		begin
			level_o  = 3'h2;
			onehot_o = 4'h2;
		end
		else if (enabled[0])
		begin
			level_o  = 3'h1;
			onehot_o = 4'h1;
		end
	end
endmodule : prhi_irq_sel

/* hdl/prhi_map.svh */
// offsets, field positions, reset values and slot addresses of the run/halt block
`ifndef PRHI_MAP_SVH
`define PRHI_MAP_SVH

`define PRHI_ACTIVE_BIT   11
`define PRHI_MASK_HI      15
`define PRHI_MASK_LO      12
`define PRHI_FLAG_HI      2
`define PRHI_FLAG_LO      0
`define PRHI_HALT_BIT     0
`define PRHI_RUN_BIT      1
`define PRHI_MASK_ALL     4'hf

`define PRHI_STATUS_RST   16'hf000
`define PRHI_PC_RST       16'h0000
`define PRHI_HRC_RST      2'h1

`define PRHI_NUM_REGS     13
`define PRHI_IDX_PC       4'h0
`define PRHI_IDX_STATUS   4'h1
`define PRHI_IDX_HRC      4'h2
`define PRHI_IDX_GP_LO    4'h3
`define PRHI_NUM_GP       10

`define PRHI_LVL_UNIMPL   3'h5
`define PRHI_LVL_ABORT    3'h6
`define PRHI_SELF5_BASE   16'h0020
`define PRHI_SELF6_BASE   16'h0028
`define PRHI_PROC_STRIDE  16'h0010
`define PRHI_CPU_NUM      2'h0

`define PRHI_W_ITEM       2'h0
`define PRHI_W_STATUS     2'h1
`define PRHI_W_PC         2'h2
`define PRHI_W_VECTOR     2'h3

`endif

/* hdl/prhi_pkg.sv */
// types shared by the run/halt and interrupt sequencer
package prhi_pkg;

	typedef enum logic [3:0]
	{
		PRHI_ST_HALT,
		PRHI_ST_IDLE,
		PRHI_ST_ACTIVE,
		PRHI_ST_EXEC,
		PRHI_ST_WAIT,
		PRHI_ST_SAVE,
		PRHI_ST_VECT,
		PRHI_ST_RESTORE
	} prhi_state_t;

	// end-of-instruction report from the datapath
	typedef struct packed
	{
		logic        done;
		logic        return_from_interrupt;
		logic        wait_op;
		logic        unimpl;
		logic        abort;
		logic        flag_we;
		logic [2:0]  flags;
		logic        st_we;
		logic [15:0] st_val;
		logic [15:0] next_pc;
		logic [15:0] item;
	} prhi_instr_t;

	// control panel register access
	typedef struct packed
	{
		logic        sel;
		logic        wr;
		logic [3:0]  idx;
		logic [15:0] wdata;
	} prhi_panel_t;

	// datapath write into the general registers
	typedef struct packed
	{
		logic        we;
		logic [3:0]  idx;
		logic [15:0] data;
	} prhi_gp_wr_t;

	// executive memory request
	typedef struct packed
	{
		logic        req;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} prhi_mem_t;

endpackage : prhi_pkg

/* hdl/prhi_slot_addr.sv */
// executive memory address of one word of an interrupt slot
`timescale 1ns/1ps
`include "prhi_map.svh"
module prhi_slot_addr
(
	input  wire logic [2:0]  level_i,    // 1..4 system, 5..6 self
	input  wire logic [1:0]  proc_num_i, // processor number 0..3
	input  wire logic [1:0]  word_i,     // word within the slot
	output logic [15:0]      addr_o      // byte address
);
	function automatic logic [15:0] slot_base(input logic [2:0] lvl,
		input logic [1:0] pn);
		logic [2:0]  lm1;
		logic [15:0] poff;
		lm1  = lvl - 3'h1;
		poff = 16'({pn, 4'h0});
		if (lvl == `PRHI_LVL_UNIMPL)
			slot_base = `PRHI_SELF5_BASE + poff;
		else if (lvl == `PRHI_LVL_ABORT)
			slot_base = `PRHI_SELF6_BASE + poff;
		else
			slot_base = 16'({lm1[1:0], 3'h0});
	endfunction : slot_base

	assign addr_o = slot_base(level_i, proc_num_i) + 16'({word_i, 1'b0});
endmodule : prhi_slot_addr

/* verification/prhi_mem_model.sv */
// executive memory partner answering the sequencer's word requests
`timescale 1ns/1ps
module prhi_mem_model
(
	input  wire logic                 core_clk_i,  // processor clock
	input  wire logic                 rst_i,       // async reset, high
	input  wire prhi_pkg::prhi_mem_t  mem_i,       // word request
	input  wire logic                 slow_i,      // add two wait cycles
	output logic                      mem_ack_o,   // word done pulse
	output logic [15:0]               mem_rdata_o  // read data with ack
);
	logic [15:0] word [0:127];
	logic [1:0]  wait_cnt;

	// outside an ack the data lines invert every cycle, so old data shows every other cycle
	always @(posedge core_clk_i or posedge rst_i)
		if (rst_i)
		begin
			mem_ack_o   <= 1'b0;
			wait_cnt    <= 2'h0;
			mem_rdata_o <= 16'h5a5a;
		end
		else if (!mem_ack_o && mem_i.req && wait_cnt == (slow_i ? 2'h2 : 2'h0))
		begin
			mem_ack_o <= 1'b1;
			wait_cnt  <= 2'h0;
			if (mem_i.wr)
				word[mem_i.addr[7:1]] <= mem_i.wdata;
			else
				mem_rdata_o <= word[mem_i.addr[7:1]];
		end
		else
		begin
			mem_ack_o   <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o;
			if (!mem_ack_o && mem_i.req)
				wait_cnt <= wait_cnt + 2'h1;
		end
endmodule : prhi_mem_model

/* verification/tb.sv */
// self-checking bench for the run/halt and interrupt sequencer
`timescale 1ns/1ps
module tb;
	logic                  core_clk_i;
	logic                  rst_i;
	logic                  step_req_i;
	logic                  panel_ack_o;
	logic                  instr_start_o;
	logic                  inhibit;
	logic                  slow;
	logic                  cpu_strap;
	logic                  mem_ack_i;
	logic                  bus_release_o;
	logic                  halted_o;
	logic [1:0]            proc_num_o;
	logic [3:0]            sys_irq_i;
	logic [3:0]            sys_irq_ack_o;
	logic [3:0]            last_ack;
	logic [15:0]           panel_rdata_o;
	logic [15:0]           sys_mod_addr_i;
	logic [15:0]           mem_rdata_i;
	logic [15:0]           status_o;
	logic [15:0]           pc_o;
	logic [15:0]           rd;
	prhi_pkg::prhi_panel_t panel_i;
	prhi_pkg::prhi_instr_t instr_i;
	prhi_pkg::prhi_instr_t plan;
	prhi_pkg::prhi_mem_t   mem_o;
	int                    fail_count;
	int                    tests_run;
	int                    n_instr;
	int                    n_ack;
	int                    n_rel;

	prhi_core prhi_core_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.bus_control_unit_i(cpu_strap), .proc_num_i(2'h2),
		.panel_i(panel_i),
		.step_req_i(step_req_i), .panel_rdata_o(panel_rdata_o),
		.panel_ack_o(panel_ack_o), .instr_start_o(instr_start_o),
		.instr_i(instr_i), .gp_wr_i('0), .sys_irq_i(sys_irq_i),
		.sys_mod_addr_i(sys_mod_addr_i), .master_interrupt_inhibit_i(inhibit),
		.sys_irq_ack_o(sys_irq_ack_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i), .bus_release_o(bus_release_o),
		.halted_o(halted_o), .status_o(status_o), .pc_o(pc_o),
		.proc_num_o(proc_num_o));

	prhi_mem_model prhi_mem_model_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.mem_i(mem_o), .slow_i(slow), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i));

	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : tick

	task chk_word(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task chk_count(input int got, input int exp);
		tests_run++;
		if (got != exp)
		begin
			fail_count++;
			$display("ERROR %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_count

	task close_out;
		$display("mismatches %0d comparisons %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	task panel(input logic wr, input logic [3:0] idx, input logic [15:0] wd);
		panel_i = '{sel: 1'b1, wr: wr, idx: idx, wdata: wd};
		tick(1);
		panel_i = '0;
		rd = panel_rdata_o;
		chk_word({15'h0, panel_ack_o}, 16'h0001);
		tick(1);
	endtask : panel

	task wait_pc(input logic [15:0] v);
		for (int i = 0; i < 300 && pc_o !== v; i++)
			tick(1);
		chk_word(pc_o, v);
	endtask : wait_pc

	task wait_halt;
		for (int i = 0; i < 300 && halted_o !== 1'b1; i++)
			tick(1);
		chk_word({15'h0, halted_o}, 16'h0001);
	endtask : wait_halt

	// datapath stand-in: ends each started instruction two cycles later
	always @(negedge core_clk_i)
		if (instr_start_o === 1'b1)
		begin
			n_instr++;
			tick(2);
			instr_i = plan;
			instr_i.done = 1'b1;
			instr_i.next_pc = pc_o + 16'h0002;
			tick(1);
			instr_i = '0;
		end

	always @(negedge core_clk_i)
	begin
		if (sys_irq_ack_o !== 4'h0)
		begin
			n_ack++;
			last_ack = sys_irq_ack_o;
		end
		if (bus_release_o === 1'b1)
			n_rel++;
	end

	task t_reset;
		chk_word({14'h0, proc_num_o}, 16'h0000);
		panel(1'b0, 4'h2, 16'h0);
		chk_word(rd, 16'h0001);
		panel(1'b0, 4'h1, 16'h0);
		chk_word(rd, 16'hf000);
		panel(1'b1, 4'h3, 16'hbeef);
		panel(1'b0, 4'h3, 16'h0);
		chk_word(rd, 16'hbeef);
		panel(1'b0, 4'hd, 16'h0);
		chk_word(rd, 16'h0000);
	endtask : t_reset

	task t_step;
		int k;
		k = n_instr;
		panel(1'b1, 4'h2, 16'h0003);
		plan.flag_we = 1'b1;
		plan.flags = 3'h5;
		step_req_i = 1'b1;
		tick(1);
		step_req_i = 1'b0;
		tick(12);
		plan = '0;
		chk_count(n_instr, k + 1);
		chk_word(pc_o, 16'h0002);
		chk_word({15'h0, halted_o}, 16'h0001);
		panel(1'b0, 4'h1, 16'h0);
		chk_word(rd, 16'hf005);
	endtask : t_step

	task t_irq;
		int k;
		prhi_mem_model_i.word[11] = 16'h0200;
		panel(1'b1, 4'h1, 16'h4000);
		sys_irq_i = 4'h4;
		sys_mod_addr_i = 16'h1234;
		k = n_instr;
		panel(1'b1, 4'h2, 16'h0002);
		tick(20);
		chk_count(n_ack, 0);
		chk_count(n_instr, k);
		chk_word({15'h0, halted_o}, 16'h0000);
		panel(1'b0, 4'h2, 16'h0);
		chk_word(rd, 16'h0002);
		panel(1'b0, 4'h1, 16'h0);
		chk_word(rd, 16'h0000);
		panel(1'b1, 4'h2, 16'h0001);
		wait_halt();
		panel(1'b1, 4'h1, 16'h0800);
		inhibit = 1'b1;
		panel(1'b1, 4'h2, 16'h0002);
		tick(20);
		chk_count(n_ack, 0);
		chk_count(32'(n_instr > k), 1);
		slow = 1'b1;
		inhibit = 1'b0;
		wait_pc(16'h0200);
		sys_irq_i = 4'h0;
		chk_word({12'h0, last_ack}, 16'h0004);
		chk_word(prhi_mem_model_i.word[8], 16'h1234);
		chk_word(prhi_mem_model_i.word[9], 16'h0800);
		chk_word({12'h0, status_o[15:12]}, 16'h000f);
		prhi_mem_model_i.word[9] = 16'h0801;
		prhi_mem_model_i.word[10] = 16'h0300;
		plan.return_from_interrupt = 1'b1;
		wait_pc(16'h0300);
		plan = '0;
		chk_word(status_o, 16'h0801);
		sys_mod_addr_i = 16'h4321;
		sys_irq_i = 4'h4;
		wait_pc(16'h0200);
		sys_irq_i = 4'h0;
		chk_word(prhi_mem_model_i.word[8], 16'h4321);
		chk_word(prhi_mem_model_i.word[9], 16'h0801);
	endtask : t_irq

	task t_self;
		int r;
		prhi_mem_model_i.word[19] = 16'h0500;
		prhi_mem_model_i.word[23] = 16'h0400;
		for (int k = 0; k < 2; k++)
		begin
			r = n_rel;
			plan.abort = (k == 1);
			plan.unimpl = (k == 0);
			plan.item = 16'hbad0 + 16'(k);
			wait_pc(k ? 16'h0400 : 16'h0500);
			plan = '0;
			chk_word(prhi_mem_model_i.word[k ? 20 : 16], 16'hbad0 + 16'(k));
			chk_count(32'(n_rel > r), k);
		end
	endtask : t_self

	task t_halt;
		int k;
		panel(1'b1, 4'h2, 16'h0001);
		wait_halt();
		k = n_instr;
		tick(10);
		chk_count(n_instr, k);
		panel(1'b1, 4'h2, 16'h0000);
		tick(20);
		chk_count(n_instr, k);
		chk_word({15'h0, halted_o}, 16'h0001);
	endtask : t_halt

	// mid-run reset as secondary number 2: no system levels, own slots
	task t_second;
		int k;
		cpu_strap = 1'b0;
		rst_i = 1'b1;
		tick(2);
		rst_i = 1'b0;
		tick(1);
		chk_word({14'h0, proc_num_o}, 16'h0002);
		prhi_mem_model_i.word[35] = 16'h0600;
		panel(1'b1, 4'h1, 16'h0800);
		sys_irq_i = 4'h1;
		k = n_ack;
		plan.unimpl = 1'b1;
		plan.item = 16'h5a01;
		panel(1'b1, 4'h2, 16'h0002);
		wait_pc(16'h0600);
		plan = '0;
		chk_count(n_ack, k);
		chk_word(prhi_mem_model_i.word[32], 16'h5a01);
		sys_irq_i = 4'h0;
		plan.wait_op = 1'b1;
		tick(12);
		plan = '0;
		k = n_instr;
		tick(10);
		chk_count(n_instr, k);
		chk_word({15'h0, halted_o}, 16'h0000);
		panel(1'b1, 4'h2, 16'h0001);
		wait_halt();
	endtask : t_second

	initial
	begin
		rst_i = 1'b1;
		panel_i = '0;
		step_req_i = 1'b0;
		instr_i = '0;
		plan = '0;
		sys_irq_i = 4'h0;
		sys_mod_addr_i = 16'h0;
		inhibit = 1'b0;
		slow = 1'b0;
		cpu_strap = 1'b1;
		fail_count = 0;
		tests_run = 0;
		n_instr = 0;
		n_ack = 0;
		n_rel = 0;
		tick(20);
		rst_i = 1'b0;
		tick(1);
		t_reset();
		t_step();
		t_irq();
		t_self();
		t_halt();
		t_second();
		close_out();
	end

	initial
	begin
		#100000;
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		close_out();
	end
endmodule : tb
